// ### core/lbr_bus_seq.sv
// multiplexed local bus sequencer with reset entry and acknowledge
// assumes one clock; pins are sampled synchronously to clk_in
// pads resolve each pin from its enable
`timescale 1ns/1ps

// Function
// R1 - address latch strobe high one clock period
// R2 - address valid half period before strobe falls
// R3 - address held half period after strobe falls
// R4 - chip select asserted before latch strobe falls
// R5 - read/write strobe half period after latch
// R6 - strobe active two periods plus waits
// R7 - data bus floated by read strobe fall
// R8 - next address one period after read
// R9 - write data held one period after strobe
// R10 - chip select spacing of half periods
// R11 - test pin request held around reset release
// R12 - two acknowledge pulses, four periods apart
// R13 - cascade select eight before, four after
// R14 - controller output within resolution time
// R15 - request low time rearms edge detector
// R16 - reset input synchronised before use
// R17 - reset held low from power on
// R18 - reset aborts cycle, drive then float
// R19 - lock and upper address float in reset
// R20 - only test pin may be pulled low
// R21 - halt cycle invalid address, controls inactive
// R22 - address lines zero in low power
// R23 - intervals counted in half clock periods
module lbr_bus_seq (
  input  wire logic                         clk_in,
  input  wire logic                         rst_b_in,
  input  wire logic                         reset_input_n_in,
  input  wire logic                         req_valid_in,
  input  wire lbr_pkg::lbr_req_s            req_in,
  output logic                              req_ready_out,
  output logic                              rsp_valid_out,
  output logic [15:0]                       rsp_data_out,
  input  wire logic                         ready_in,
  input  wire logic                         lowpower_in,
  input  wire logic [15:0]                  ad_in,
  input  wire logic                         top_addr_in,
  input  wire logic [lbr_pkg::NUM_IRQ-1:0]  irq_in,
  input  wire logic [lbr_pkg::NUM_IRQ-1:0]  irq_mask_in,
  output logic                              int_request_out,
  output logic                              test_float_mode_out,
  output lbr_pkg::lbr_pins_s                pins_out
);

  lbr_pkg::lbr_core_s cur_ff;   // registered state
  lbr_pkg::lbr_core_s nxt_ff;   // next state
  lbr_pkg::lbr_pins_s pins;     // decoded pin drive
  logic               rst_req;  // synchronised reset request
  logic               idle_ok;  // sequencer may take a request

  // reset pin synchroniser
  lbr_reset_sync u_rsync (
    .clk_in           (clk_in),
    .rst_b_in         (rst_b_in),
    .reset_input_n_in (reset_input_n_in),
    .rst_req_out      (rst_req)
  );

  // irq front end, cleared by first ack
  lbr_irq_front u_irq (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .irq_in   (irq_in),
    .mask_in  (irq_mask_in),
    .clear_in (cur_ff.irq_clr),
    .int_out  (int_request_out)
  );

  // true for a write request
  function automatic logic is_write(input lbr_pkg::lbr_kind_e k);
    is_write = (k == lbr_pkg::LBR_WR);
  endfunction : is_write

  // counter start for n cycles
  function automatic logic [4:0] span(input logic [4:0] n);
    span = n - 5'h01;
  endfunction : span

  assign idle_ok = (cur_ff.state == lbr_pkg::ST_IDLE) && !rst_req &&
                   !cur_ff.test_float;

  // sequencer next state
  always_comb
  begin
    nxt_ff           = cur_ff;
    nxt_ff.clk_div   = ~cur_ff.clk_div;
    nxt_ff.rsp_valid = 1'b0;
    nxt_ff.irq_clr   = 1'b0;
    // every interval counts down in half periods
    if (cur_ff.cnt != 5'h00)
      nxt_ff.cnt = cur_ff.cnt - 5'h01;  // R23
    if (rst_req)
    begin
      // abort: one cycle inactive, then float
      if (cur_ff.state == lbr_pkg::ST_RST_DRIVE ||
          cur_ff.state == lbr_pkg::ST_RST_FLOAT)
        nxt_ff.state = lbr_pkg::ST_RST_FLOAT;  // R18
      else
        nxt_ff.state = lbr_pkg::ST_RST_DRIVE;  // R18
      nxt_ff.cnt = 5'h00;
      // test pin, last reset cycle wins
      nxt_ff.cap_float = ~top_addr_in;  // R11
      nxt_ff.last_read = 1'b1;
    end
    else
    begin
      case (cur_ff.state)
        lbr_pkg::ST_RST_DRIVE,
        lbr_pkg::ST_RST_FLOAT:
        begin
          // release: latch test float request
          nxt_ff.state      = lbr_pkg::ST_IDLE;
          nxt_ff.test_float = cur_ff.cap_float;  // R11
        end
        lbr_pkg::ST_IDLE:
        begin
          if (req_valid_in && idle_ok)
          begin
            nxt_ff.req = req_in;
            case (req_in.kind)
              lbr_pkg::LBR_RD,
              lbr_pkg::LBR_WR:
              begin
                nxt_ff.state = lbr_pkg::ST_ADDR;
                nxt_ff.cnt   = span(lbr_pkg::ALE_CYC);  // R1
              end
              lbr_pkg::LBR_IACK:
              begin
                nxt_ff.state = lbr_pkg::ST_IA_LEAD;
                nxt_ff.cnt   = span(lbr_pkg::IA_LEAD_CYC);  // R13
              end
              default:
              begin
                nxt_ff.state = lbr_pkg::ST_HALT;
                nxt_ff.cnt   = span(lbr_pkg::HALT_CYC);
              end
            endcase
          end
        end
        lbr_pkg::ST_ADDR:
        begin
          if (cur_ff.cnt == 5'h00)
          begin
            nxt_ff.state = lbr_pkg::ST_AHOLD;
            nxt_ff.cnt   = span(lbr_pkg::AHOLD_CYC);  // R3
          end
        end
        lbr_pkg::ST_AHOLD:
        begin
          if (cur_ff.cnt == 5'h00)
          begin
            nxt_ff.state = lbr_pkg::ST_STROBE;
            nxt_ff.cnt   = span(lbr_pkg::STROBE_CYC);  // R5
          end
        end
        lbr_pkg::ST_STROBE:
        begin
          if (cur_ff.cnt == 5'h00)
          begin
            if (!ready_in)
              nxt_ff.cnt = span(lbr_pkg::WAIT_CYC);  // R6
            else
            begin
              nxt_ff.state     = lbr_pkg::ST_RECOV;
              nxt_ff.cnt       = span(lbr_pkg::RECOV_CYC);  // R8
              nxt_ff.rdata     = ad_in;
              nxt_ff.rsp_valid = 1'b1;
              nxt_ff.last_read = ~is_write(cur_ff.req.kind);
            end
          end
        end
        lbr_pkg::ST_RECOV:
        begin
          if (cur_ff.cnt == 5'h00)
            nxt_ff.state = lbr_pkg::ST_IDLE;
        end
        lbr_pkg::ST_IA_LEAD:
        begin
          if (cur_ff.cnt == 5'h00)
          begin
            nxt_ff.state   = lbr_pkg::ST_IA_P1;
            nxt_ff.cnt     = span(lbr_pkg::IA_LOW_CYC);  // R12
            nxt_ff.irq_clr = 1'b1;
          end
        end
        lbr_pkg::ST_IA_P1:
        begin
          if (cur_ff.cnt == 5'h00)
          begin
            nxt_ff.state = lbr_pkg::ST_IA_GAP;
            nxt_ff.cnt   = span(lbr_pkg::IA_GAP_CYC);  // R12
          end
        end
        lbr_pkg::ST_IA_GAP:
        begin
          if (cur_ff.cnt == 5'h00)
          begin
            nxt_ff.state = lbr_pkg::ST_IA_P2;
            nxt_ff.cnt   = span(lbr_pkg::IA_LOW_CYC);  // R12
          end
        end
        lbr_pkg::ST_IA_P2:
        begin
          if (cur_ff.cnt == 5'h00)
          begin
            // vector sampled as the second pulse ends
            nxt_ff.state = lbr_pkg::ST_IA_HOLD;
            nxt_ff.cnt   = span(lbr_pkg::CAS_HOLD_CYC -
                                lbr_pkg::IA_LOW_CYC);  // R13
            nxt_ff.rdata = ad_in;
          end
        end
        lbr_pkg::ST_IA_HOLD:
        begin
          if (cur_ff.cnt == 5'h00)
          begin
            nxt_ff.state     = lbr_pkg::ST_IDLE;
            nxt_ff.rsp_valid = 1'b1;
            nxt_ff.last_read = 1'b1;
          end
        end
        lbr_pkg::ST_HALT:
        begin
          if (cur_ff.cnt == 5'h00)
          begin
            nxt_ff.state     = lbr_pkg::ST_IDLE;
            nxt_ff.rsp_valid = 1'b1;
          end
        end
        default:
        begin
          nxt_ff.state = lbr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // pin decode from the registered state
  always_comb
  begin
    pins              = '0;
    pins.rd_n         = 1'b1;
    pins.wr_n         = 1'b1;
    pins.cs_n         = 1'b1;
    pins.int_ack_strobe_n       = 1'b1;
    pins.lock_n       = ~cur_ff.req.lock;
    pins.top_addr     = cur_ff.req.addr[19];
    pins.upper        = cur_ff.req.addr[18:16];
    pins.ad           = cur_ff.req.addr[15:0];
    pins.ad_oe_n      = 1'b1;
    pins.clock_output = cur_ff.clk_div;
    case (cur_ff.state)
      lbr_pkg::ST_ADDR:
      begin
        pins.ale     = 1'b1;  // R1
        pins.cs_n    = 1'b0;  // R4
        pins.ad_oe_n = 1'b0;  // R2
      end
      lbr_pkg::ST_AHOLD:
      begin
        pins.cs_n    = 1'b0;
        pins.ad_oe_n = 1'b0;  // R3
      end
      lbr_pkg::ST_STROBE:
      begin
        pins.cs_n = 1'b0;
        if (is_write(cur_ff.req.kind))
        begin
          pins.wr_n    = 1'b0;  // R6
          pins.ad      = cur_ff.req.wdata;
          pins.ad_oe_n = 1'b0;
        end
        else
        begin
          pins.rd_n = 1'b0;  // R7
        end
      end
      lbr_pkg::ST_RECOV:
      begin
        // select half a period, then idle
        pins.cs_n = (cur_ff.cnt < lbr_pkg::RECOV_CYC -
                     lbr_pkg::RECOV_CS_CYC);  // R10
        if (is_write(cur_ff.req.kind))
        begin
          pins.ad      = cur_ff.req.wdata;
          pins.ad_oe_n = 1'b0;  // R9
        end
      end
      lbr_pkg::ST_IA_LEAD,
      lbr_pkg::ST_IA_GAP,
      lbr_pkg::ST_IA_HOLD:
      begin
        pins.cas = cur_ff.req.cas;  // R13
      end
      lbr_pkg::ST_IA_P1,
      lbr_pkg::ST_IA_P2:
      begin
        pins.cas    = cur_ff.req.cas;
        pins.int_ack_strobe_n = 1'b0;  // R12
      end
      lbr_pkg::ST_HALT:
      begin
        // data floats after a read, acknowledge or reset
        pins.ad_oe_n = cur_ff.last_read;  // R21
      end
      lbr_pkg::ST_RST_DRIVE:
      begin
        pins.lock_n = 1'b1;  // R18
      end
      lbr_pkg::ST_RST_FLOAT:
      begin
        pins.ctl_oe_n   = 1'b1;  // R18
        pins.lock_oe_n  = 1'b1;  // R19
        pins.top_oe_n   = 1'b1;  // R19
        pins.upper_oe_n = 1'b1;  // R19
      end
      default:
      begin
        pins.lock_n = 1'b1;
        if (lowpower_in)
        begin
          pins.top_addr = 1'b0;  // R22
          pins.upper    = 3'h0;  // R22
          pins.ad       = 16'h0000;
          pins.ad_oe_n  = 1'b0;  // R22
        end
      end
    endcase
    // test float releases every pin but cas and clock_output
    if (cur_ff.test_float)
    begin
      pins.ctl_oe_n   = 1'b1;
      pins.lock_oe_n  = 1'b1;
      pins.top_oe_n   = 1'b1;
      pins.upper_oe_n = 1'b1;
      pins.ad_oe_n    = 1'b1;
    end
  end

  // state register; comes up as if in reset
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cur_ff           <= '0;
      cur_ff.state     <= lbr_pkg::ST_RST_FLOAT;
      cur_ff.last_read <= 1'b1;
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  assign req_ready_out       = idle_ok;
  assign rsp_valid_out       = cur_ff.rsp_valid;
  assign rsp_data_out        = cur_ff.rdata;
  assign test_float_mode_out = cur_ff.test_float;
  assign pins_out            = pins;

endmodule : lbr_bus_seq

// ### core/lbr_pkg.sv
// constants, enums and structs of the bus sequencer
// assumes clk_in at 40 MHz; clock_output is clk_in divided by two
package lbr_pkg;

  // clock and bus period figures
  localparam int unsigned CLK_PERIOD_NS = 25;  // clk_in period
  localparam int unsigned CLOCK_OUTPUT_DIV    = 2;   // clk_in cycles per T
  localparam int unsigned HALF_T_CYC    = CLOCK_OUTPUT_DIV / 2;

  // bus intervals in clk_in cycles
  localparam logic [4:0] ALE_CYC      = 5'(2 * HALF_T_CYC);  // one T
  localparam logic [4:0] AHOLD_CYC    = 5'(1 * HALF_T_CYC);  // half T
  localparam logic [4:0] STROBE_CYC   = 5'(4 * HALF_T_CYC);  // two T
  localparam logic [4:0] WAIT_CYC     = 5'(2 * HALF_T_CYC);  // one T
  localparam logic [4:0] RECOV_CYC    = 5'(2 * HALF_T_CYC);  // one T
  localparam logic [4:0] RECOV_CS_CYC = 5'(1 * HALF_T_CYC);  // half T
  localparam logic [4:0] HALT_CYC     = 5'(2 * HALF_T_CYC);  // one T

  // acknowledge intervals
  localparam logic [4:0] IA_LOW_CYC   = 5'(4 * HALF_T_CYC);   // two T
  localparam logic [4:0] IA_GAP_CYC   = 5'(8 * HALF_T_CYC);   // four T
  localparam logic [4:0] CAS_SU_CYC   = 5'(16 * HALF_T_CYC);  // eight T
  localparam logic [4:0] CAS_HOLD_CYC = 5'(8 * HALF_T_CYC);   // four T
  localparam logic [4:0] IA_LEAD_CYC  = 5'(CAS_SU_CYC - IA_LOW_CYC
                                           - IA_GAP_CYC);

  // interrupt request timing
  localparam int unsigned IRES_NS  = 150;  // longest resolution time
  localparam int unsigned IRES_CYC = (IRES_NS / CLK_PERIOD_NS < 1) ? 1 :
                                     IRES_NS / CLK_PERIOD_NS;
  localparam int unsigned IRLH_NS  = 50;   // least low time to rearm
  localparam int unsigned IRLH_CYC = (IRLH_NS + CLK_PERIOD_NS - 1) /
                                     CLK_PERIOD_NS;
  localparam int unsigned IRLH_W   = 3;    // low counter width
  localparam int unsigned NUM_IRQ  = 8;    // request lines
  localparam int unsigned CASC_IDX = 7;    // line through two stages

  // request kinds
  typedef enum logic [1:0] {
    LBR_RD,
    LBR_WR,
    LBR_IACK,
    LBR_HALT
  } lbr_kind_e;

  // bus sequencer states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_AHOLD,
    ST_STROBE,
    ST_RECOV,
    ST_IA_LEAD,
    ST_IA_P1,
    ST_IA_GAP,
    ST_IA_P2,
    ST_IA_HOLD,
    ST_HALT,
    ST_RST_DRIVE,
    ST_RST_FLOAT
  } lbr_state_e;

  // one request from the core side
  typedef struct packed {
    lbr_kind_e   kind;   // read, write, acknowledge, halt
    logic        lock;   // hold the bus lock during the cycle
    logic [19:0] addr;   // full address
    logic [15:0] wdata;  // write data
    logic [2:0]  cas;    // cascade select for acknowledge
  } lbr_req_s;

  // pin drive; _oe_n low = driven
  typedef struct packed {
    logic        ale;
    logic        rd_n;
    logic        wr_n;
    logic        cs_n;
    logic        int_ack_strobe_n;
    logic        ctl_oe_n;
    logic        lock_n;
    logic        lock_oe_n;
    logic        top_addr;
    logic        top_oe_n;
    logic [2:0]  upper;
    logic        upper_oe_n;
    logic [15:0] ad;
    logic        ad_oe_n;
    logic [2:0]  cas;
    logic        clock_output;
  } lbr_pins_s;

  // main sequencer state
  typedef struct packed {
    lbr_state_e  state;
    logic [4:0]  cnt;        // cycles left in this state after this one
    logic        clk_div;    // clock output divider
    logic        last_read;  // previous cycle left the data bus floated
    lbr_req_s    req;        // request being served
    logic [15:0] rdata;      // captured read data or vector
    logic        rsp_valid;  // completion pulse
    logic        irq_clr;    // first acknowledge pulse started
    logic        cap_float;  // test pin sampled low during reset
    logic        test_float; // all pins but cas and clock_output floated until the next reset is released
  } lbr_core_s;

  // reset synchroniser state
  typedef struct packed {
    logic meta;
    logic sync;
  } lbr_rsync_s;

  // interrupt front end state
  typedef struct packed {
    logic [NUM_IRQ-1:0]             prev;
    logic [NUM_IRQ-1:0][IRLH_W-1:0] lowc;
    logic [NUM_IRQ-1:0]             armed;
    logic [NUM_IRQ-1:0]             pending;
    logic                           casc;
    logic                           intr;
  } lbr_irq_s;

endpackage : lbr_pkg

// ### core/lbr_reset_sync.sv
// two-flop synchroniser for the reset input pin
// assumes the pin is low for reset and clk_in is running
`timescale 1ns/1ps

module lbr_reset_sync (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic reset_input_n_in,
  output logic      rst_req_out
);

  lbr_pkg::lbr_rsync_s cur_ff;  // registered state
  lbr_pkg::lbr_rsync_s nxt_ff;  // next state

  // first flop feeds only the second
  always_comb
  begin
    nxt_ff.meta = ~reset_input_n_in;  // R16
    nxt_ff.sync = cur_ff.meta;
  end

  // registers come up in reset
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cur_ff <= '{meta: 1'b1, sync: 1'b1};
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  assign rst_req_out = cur_ff.sync;  // R16

endmodule : lbr_reset_sync

// ### core/lbr_irq_front.sv
// edge-triggered interrupt request front end with a cascaded line
// assumes requests are synchronous to clk_in and active high
`timescale 1ns/1ps

module lbr_irq_front (
  input  wire logic                         clk_in,
  input  wire logic                         rst_b_in,
  input  wire logic [lbr_pkg::NUM_IRQ-1:0]  irq_in,
  input  wire logic [lbr_pkg::NUM_IRQ-1:0]  mask_in,
  input  wire logic                         clear_in,
  output logic                              int_out
);

  lbr_pkg::lbr_irq_s cur_ff;  // registered state
  lbr_pkg::lbr_irq_s nxt_ff;  // next state
  logic [lbr_pkg::NUM_IRQ-1:0] active;  // unmasked pending lines
  logic [lbr_pkg::NUM_IRQ-1:0] direct;  // lines through one stage

  localparam int unsigned IRLH_W = lbr_pkg::IRLH_W;

  // edge detect, rearm, set over clear
  always_comb
  begin
    nxt_ff = cur_ff;
    nxt_ff.prev = irq_in;
    for (int i = 0; i < lbr_pkg::NUM_IRQ; i++)
    begin
      if (!irq_in[i])
      begin
        // count low time, saturating
        if (cur_ff.lowc[i] < IRLH_W'(lbr_pkg::IRLH_CYC))
          nxt_ff.lowc[i] = cur_ff.lowc[i] + IRLH_W'(1);
        if (cur_ff.lowc[i] >= IRLH_W'(lbr_pkg::IRLH_CYC - 1))
          nxt_ff.armed[i] = 1'b1;  // R15
      end
      if (clear_in)
        nxt_ff.pending[i] = 1'b0;
      if (irq_in[i] && !cur_ff.prev[i] && cur_ff.armed[i])
      begin
        // armed rising edge wins over clear
        nxt_ff.pending[i] = 1'b1;
        nxt_ff.armed[i]   = 1'b0;
        nxt_ff.lowc[i]    = '0;
      end
    end
    active = cur_ff.pending & ~mask_in;
    direct = active;
    direct[lbr_pkg::CASC_IDX] = 1'b0;
    // cascaded line takes one extra stage
    nxt_ff.casc = active[lbr_pkg::CASC_IDX];  // R14
    nxt_ff.intr = (|direct) | cur_ff.casc;    // R14
  end

  // state register
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cur_ff <= '0;
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  assign int_out = cur_ff.intr;

endmodule : lbr_irq_front

// ### verif/lbr_bus_mon_monitor.sv
// bus, ack, irq and reset checks
// sees only ports of lbr_bus_seq; bound from the bench top
`timescale 1ns/1ps

module lbr_mon (
  input wire logic                        clk_in,
  input wire logic                        rst_b_in,
  input wire logic                        reset_input_n_in,
  input wire logic [lbr_pkg::NUM_IRQ-1:0] irq_in,
  input wire logic [lbr_pkg::NUM_IRQ-1:0] irq_mask_in,
  input wire logic                        int_request_out,
  input wire lbr_pkg::lbr_pins_s          pins_out
);
  lbr_pkg::lbr_pins_s p;   // short alias of the pins
  logic               dr_ff; // controls driven last cycle
  logic               on;    // controls driven two cycles
  assign p = pins_out;
  assign on = dr_ff && !p.ctl_oe_n;

  // ignore edges from floating
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      dr_ff <= 1'b0;
    else
      dr_ff <= !p.ctl_oe_n;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in || !reset_input_n_in);

  AST_ALE_WIDTH: assert property ($rose(p.ale) |-> ##1 p.ale ##1 !p.ale)
    else $error("ale width");
  AST_AD_SETUP: assert property ($rose(p.ale) |->
    !p.ad_oe_n && !p.cs_n ##1 $stable(p.ad) && !p.cs_n)
    else $error("ad setup");
  AST_AD_HOLD: assert property ($fell(p.ale) |->
    (!p.ad_oe_n && $stable(p.ad) && p.rd_n && p.wr_n)
    ##1 (p.rd_n != p.wr_n))
    else $error("ad hold");
  AST_STB_WIDTH: assert property (($fell(p.rd_n) || $fell(p.wr_n))
    && on |-> (!p.rd_n || !p.wr_n)[*4])
    else $error("strobe too short");
  AST_RD_FLOAT: assert property (!p.rd_n && on |-> p.ad_oe_n)
    else $error("ad driven");
  AST_NEXT_ADDR: assert property ($rose(p.rd_n) && on |-> p.ad_oe_n[*2])
    else $error("next addr");
  AST_WR_HOLD: assert property ($rose(p.wr_n) && on |->
    (!p.ad_oe_n && $stable(p.ad))[*2])
    else $error("wr hold");
  AST_CS_SPACE: assert property (($rose(p.rd_n) || $rose(p.wr_n))
    && on |-> !p.cs_n ##1 p.cs_n[*2])
    else $error("cs space");
  AST_IA_PULSE: assert property ($fell(p.int_ack_strobe_n) && on |->
    !p.int_ack_strobe_n[*4] ##1 p.int_ack_strobe_n)
    else $error("ack width");
  AST_IA_GAP: assert property ($rose(p.int_ack_strobe_n) && on |-> p.int_ack_strobe_n[*8])
    else $error("ack gap");
  AST_CAS_HOLD: assert property ($fell(p.int_ack_strobe_n) && on |->
    $stable(p.cas)[*8])
    else $error("cas moved");
  AST_IRQ_RES: assert property ($rose(irq_in[2]) && !irq_mask_in[2]
    && !$past(irq_in[2], 2) |-> ##[1:6] int_request_out)
    else $error("int late");
  AST_IRQ_CASC: assert property ($rose(irq_in[7]) && !irq_mask_in[7]
    && !$past(irq_in[7], 2) |-> ##[1:12] int_request_out)
    else $error("casc late");
  AST_RST_FLOAT: assert property (disable iff (!rst_b_in)
    $fell(reset_input_n_in) |-> ##4 (p.ctl_oe_n && p.lock_oe_n
    && p.top_oe_n && p.upper_oe_n && p.ad_oe_n))
    else $error("no float");

  // main scenarios reached
  cover property ($fell(p.rd_n));
  cover property ($fell(p.wr_n));
  cover property ($fell(p.int_ack_strobe_n));
  cover property ($rose(int_request_out));
endmodule : lbr_mon

// ### verif/lbr_bus_mem.sv
// far side memory and vector source
// resolves the shared data bus
`timescale 1ns/1ps

module lbr_bus_mem #(
  parameter logic [15:0] VEC = 16'h0040  // vector, arbitrary
) (
  input  wire logic               clk_in,
  input  wire lbr_pkg::lbr_pins_s pins_in,
  input  wire logic [1:0]         waits_in,
  output logic                    ready_out,
  output logic [15:0]             ad_out
);
  logic [15:0] mem [16];        // word store
  logic [3:0]  adr_ff = 4'h0;   // latched address
  logic [3:0]  scnt_ff = 4'h0;  // strobe cycles so far
  logic [15:0] last_ff = 16'h0; // last bus level

  // latch address, store write data, count strobe cycles
  always_ff @(posedge clk_in)
  begin
    if (pins_in.ale)
      adr_ff <= pins_in.ad[3:0];
    if (!pins_in.wr_n && !pins_in.cs_n)
      mem[adr_ff] <= pins_in.ad;
    scnt_ff <= (pins_in.rd_n && pins_in.wr_n) ? 4'h0 : scnt_ff + 4'h1;
    last_ff <= ad_out;
  end

  // slow answer holds off ready for whole periods
  assign ready_out = (scnt_ff >= 4'(3 + 2 * waits_in));

  // bus level: sequencer, memory, vector or changing junk
  always_comb
  begin
    if (!pins_in.ad_oe_n)
      ad_out = pins_in.ad;
    else if (!pins_in.rd_n && scnt_ff != 4'h0)
      ad_out = mem[adr_ff];
    else if (!pins_in.int_ack_strobe_n)
      ad_out = VEC;
    else
      ad_out = ~last_ff;
  end
endmodule : lbr_bus_mem

// ### verif/tb.sv
// bench for the local bus sequencer
// uses the memory model and bound monitor
`timescale 1ns/1ps

module tb;
  localparam logic [15:0] VEC = 16'h0040;  // arbitrary vector
  logic               clk_in = 1'b0;  // 40 MHz
  logic               rst_b_in = 1'b0;  // chip reset
  logic               reset_input_n_in = 1'b0; // low from power on
  logic               req_valid_in = 1'b0;
  lbr_pkg::lbr_req_s  req_in = '0;
  logic               lowpower_in = 1'b0;
  logic [7:0]         irq_in = 8'h00;
  logic [7:0]         irq_mask_in = 8'h00;
  logic               tf_pull = 1'b0;  // test pin pulled low
  logic [1:0]         waits = 2'h0;  // model wait states
  logic               ready_in;
  logic [15:0]        ad_in;  // resolved bus
  logic               top_addr_in;  // resolved test pin
  logic               req_ready_out;
  logic               rsp_valid_out;
  logic [15:0]        rsp_data_out;
  logic               int_request_out;
  logic               test_float_mode_out;
  lbr_pkg::lbr_pins_s pins_out;
  lbr_pkg::lbr_pins_s p1;  // pins in first cycle
  int                 failures = 0;
  int                 samples_checked = 0;

  // clock
  always #12.5 clk_in = ~clk_in;

  // pull-up on the test pin unless pulled low
  assign top_addr_in = pins_out.top_oe_n ? !tf_pull : pins_out.top_addr;

  lbr_bus_seq dut_u (.clk_in, .rst_b_in, .reset_input_n_in, .req_valid_in,
    .req_in, .req_ready_out, .rsp_valid_out, .rsp_data_out, .ready_in,
    .lowpower_in, .ad_in, .top_addr_in, .irq_in, .irq_mask_in,
    .int_request_out, .test_float_mode_out, .pins_out);

  lbr_bus_mem #(.VEC(VEC)) mem_u (.clk_in, .pins_in(pins_out),
    .waits_in(waits), .ready_out(ready_in), .ad_out(ad_in));

  task automatic wrap_up;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one request; cycles from take to completion
  task automatic do_req(input lbr_pkg::lbr_kind_e k,
                        input logic [15:0] a, input logic [2:0] c,
                        output int n);
    req_in = '{k, 1'b0, {4'h0, a}, ~a, c};
    req_valid_in = 1'b1;
    for (int i = 0; i < 40 && req_ready_out !== 1'b1; i++)
      @(negedge clk_in);
    chk("ready", 16'h0001, {15'h0, req_ready_out});
    @(negedge clk_in);
    req_valid_in = 1'b0;
    p1 = pins_out;
    for (n = 1; n < 60 && rsp_valid_out !== 1'b1; n++)
      @(negedge clk_in);
    chk("done", 16'h0001, {15'h0, rsp_valid_out});
    if (rsp_valid_out !== 1'b1)
      wrap_up();
  endtask : do_req

  task automatic wt_int(input int lim);
    for (int i = 0; i < lim && int_request_out !== 1'b1; i++)
      @(negedge clk_in);
    chk("int raised", 16'h0001, {15'h0, int_request_out});
  endtask : wt_int

  // write, read back, read with a wait
  task automatic t_rw;
    int n0, n1;
    do_req(lbr_pkg::LBR_WR, 16'h0005, 3'h0, n0);
    do_req(lbr_pkg::LBR_RD, 16'h0005, 3'h0, n0);
    chk("read data", 16'hFFFA, rsp_data_out);
    waits = 2'h1;
    do_req(lbr_pkg::LBR_RD, 16'h0005, 3'h0, n1);
    waits = 2'h0;
    chk("wait stretch", 16'h0002, 16'(n1 - n0));
  endtask : t_rw

  // halt floats data after a read, drives it after a write
  task automatic t_halt;
    int n;
    do_req(lbr_pkg::LBR_RD, 16'h0005, 3'h0, n);
    do_req(lbr_pkg::LBR_HALT, 16'h0000, 3'h0, n);
    chk("halt float", 16'h0001, {15'h0, p1.ad_oe_n});
    chk("halt ctl", 16'h000F, {11'h0, p1.ale, p1.rd_n, p1.wr_n,
        p1.cs_n, p1.int_ack_strobe_n});
    do_req(lbr_pkg::LBR_WR, 16'h0003, 3'h0, n);
    do_req(lbr_pkg::LBR_HALT, 16'h0000, 3'h0, n);
    chk("halt drive", 16'h0000, {15'h0, p1.ad_oe_n});
  endtask : t_halt

  // ack clears, masked line, cascaded line
  task automatic t_irq;
    int n;
    irq_in[2] = 1'b1;
    wt_int(6);
    do_req(lbr_pkg::LBR_IACK, 16'h0000, 3'h5, n);
    chk("cas", 16'h0005, {13'h0, p1.cas});
    chk("vector", VEC, rsp_data_out);
    chk("cleared", 16'h0000, {15'h0, int_request_out});
    irq_in[2] = 1'b0;
    irq_mask_in[3] = 1'b1;
    irq_in[3] = 1'b1;
    repeat (8) @(negedge clk_in);
    chk("masked", 16'h0000, {15'h0, int_request_out});
    irq_in[7] = 1'b1;
    wt_int(12);
  endtask : t_irq

  // address lines zero in low power
  task automatic t_lowpower;
    lowpower_in = 1'b1;
    repeat (3) @(negedge clk_in);
    chk("lp addr", 16'h0000, pins_out.ad);
    chk("lp upper", 16'h0000, {11'h0, pins_out.upper_oe_n,
        pins_out.ad_oe_n, pins_out.upper});
    lowpower_in = 1'b0;
  endtask : t_lowpower

  // reset in mid read, test pin low at release
  task automatic t_abort;
    req_in.kind = lbr_pkg::LBR_RD;
    req_valid_in = 1'b1;
    @(negedge clk_in);
    req_valid_in = 1'b0;
    repeat (4) @(negedge clk_in);
    reset_input_n_in = 1'b0;
    tf_pull = 1'b1;
    repeat (6) @(negedge clk_in);
    chk("float", 16'h001F, {11'h0, pins_out.ctl_oe_n, pins_out.lock_oe_n,
        pins_out.top_oe_n, pins_out.upper_oe_n, pins_out.ad_oe_n});
    reset_input_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    tf_pull = 1'b0;
    repeat (4) @(negedge clk_in);
    chk("test float", 16'h0001, {15'h0, test_float_mode_out});
    chk("refused", 16'h0000, {15'h0, req_ready_out});
  endtask : t_abort

  // main sequence
  initial
  begin
    repeat (8) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (2) @(negedge clk_in);
    reset_input_n_in = 1'b1;
    t_rw();
    t_halt();
    t_irq();
    t_lowpower();
    t_abort();
    wrap_up();
  end
endmodule : tb

bind lbr_bus_seq lbr_mon mon_u (.clk_in, .rst_b_in, .reset_input_n_in,
  .irq_in, .irq_mask_in, .int_request_out, .pins_out);
